// *** hdl/cfgss_sequencer.sv ***
// configuration startup sequencer with apb control and status
// the sequencer walks phases 0..7 once loading has ended, then parks in the
// finished state until a restart is written or reset is applied
// assumes apb signals synchronous to ref_clk_i; lock and match are synchronous levels
// assumes the configuration source keeps ref_clk_i running until done is high
`timescale 1ns/1ns
`default_nettype none

module cfgss_sequencer
   import cfgss_pkg::*;
(
   input  wire logic                    ref_clk_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    psel_i,
   input  wire logic                    penable_i,
   input  wire logic                    pwrite_i,
   input  wire logic [CFGSS_ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]             pwdata_i,
   output logic      [31:0]             prdata_o,
   output logic                         pready_o,
   output logic                         pslverr_o,
   input  wire logic                    load_done_i,
   input  wire logic                    clk_lock_i,
   input  wire logic                    match_i,
   output logic                         done_o,
   output logic                         io_release_o,
   output logic                         write_enable_o,
   output logic                         bram_enable_o,
   output logic                         global_interconnect_hold_o,
   output logic                         global_set_reset_o,
   output logic [2:0]                   phase_o
);
   import cfgss_pkg::*;

   typedef struct packed
   {
      cfgss_state_type state;
      logic [31:0]     ctrl;
      logic [3:0]      phase;
      logic            done_hit;
      logic            done;
      logic            io_rel;
      logic            we;
      logic [31:0]     rdata;
   } cfgss_regs_type;

   cfgss_regs_type r;
   cfgss_regs_type next_r;

   // true when a select field names this phase
   function automatic logic cfgss_hit(input logic [3:0] sel, input logic [3:0] ph);
      cfgss_hit = (sel == ph);
   endfunction : cfgss_hit

   logic [3:0] done_sel;
   logic [3:0] io_sel;
   logic [3:0] we_sel;
   logic [3:0] lock_sel;
   logic [3:0] match_sel;
   logic       stall;
   logic       done_now;
   logic       wr;
   logic       rd;

   always_comb
   begin
      done_sel  = r.ctrl[CFGSS_DONE_LSB +: 4];
      io_sel    = r.ctrl[CFGSS_IO_LSB +: 4];
      we_sel    = r.ctrl[CFGSS_WE_LSB +: 4];
      lock_sel  = r.ctrl[CFGSS_LOCK_LSB +: 4];
      match_sel = r.ctrl[CFGSS_MATCH_LSB +: 4];
      if (match_sel == CFGSS_SEL_AUTO)
      begin
         match_sel = r.ctrl[CFGSS_CALIO_BIT] ? CFGSS_AUTO_PHASE : CFGSS_SEL_NO_WAIT_CHOICE;
      end
   end

   // single next-state process for bus access and the phase walk
   // control writes are only taken in idle, so selects never change mid-walk;
   // this trades late reconfiguration for outputs that cannot glitch
   // read data is latched at the setup edge so it stands through the access phase
   always_comb
   begin
      wr = psel_i && penable_i && pwrite_i;
      rd = psel_i && !penable_i && !pwrite_i;
      // hold in the current phase while a chosen wait is unmet
      stall = (cfgss_hit(lock_sel, r.phase) && !clk_lock_i)
           || (cfgss_hit(match_sel, r.phase) && !match_i);
      next_r = r;
      if (wr && (paddr_i == CFGSS_CTRL_OFS) && (r.state == CFGSS_IDLE))
      begin
         next_r.ctrl = pwdata_i;
      end
      if (rd)
      begin
         unique case (paddr_i)
            CFGSS_CTRL_OFS:   next_r.rdata = r.ctrl;
            CFGSS_STATUS_OFS: next_r.rdata = {22'h0, r.we, r.io_rel, r.done,
                                              r.state, 1'b0, r.phase};
            default:          next_r.rdata = 32'h0;
         endcase
      end
      // a new startup may be requested again once finished
      if (wr && (paddr_i == CFGSS_START_OFS) && pwdata_i[0] && (r.state == CFGSS_FIN))
      begin
         next_r.state    = CFGSS_IDLE;
         next_r.phase    = 4'h0;
         next_r.done_hit = 1'b0;
         next_r.done     = 1'b0;
         next_r.io_rel   = 1'b0;
         next_r.we       = 1'b0;
      end
      done_now = r.done_hit || r.done;
      unique case (r.state)
         CFGSS_IDLE:
         begin
            if (load_done_i)
            begin
               next_r.state = CFGSS_RUN;
            end
         end
         CFGSS_RUN:
         begin
            if (cfgss_hit(done_sel, r.phase))
            begin
               next_r.done_hit = 1'b1;
            end
            // pipelined done lands one clock after its phase
            if (r.ctrl[CFGSS_PIPE_BIT] ? r.done_hit : cfgss_hit(done_sel, r.phase))
            begin
               next_r.done = 1'b1;
            end
            if (cfgss_hit(io_sel, r.phase) || ((io_sel == CFGSS_SEL_DONE) && done_now))
            begin
               next_r.io_rel = 1'b1;
            end
            // block ram follows this flag, so it stays closed until here
            if (cfgss_hit(we_sel, r.phase)
                || ((we_sel == CFGSS_SEL_DONE) && done_now))
            begin
               next_r.we = 1'b1;
            end
            if (!stall)
            begin
               if (r.phase == CFGSS_LAST_PHASE)
               begin
                  next_r.state = CFGSS_FIN;
               end
               else
               begin
                  next_r.phase = r.phase + 4'h1;
               end
            end
         end
         CFGSS_FIN:
         begin
            // a pipelined done chosen at the last phase lands here
            // choices tied to done still follow it after the walk ends
            if (r.ctrl[CFGSS_PIPE_BIT] && r.done_hit)
            begin
               next_r.done = 1'b1;
            end
            if ((io_sel == CFGSS_SEL_DONE) && r.done)
            begin
               next_r.io_rel = 1'b1;
            end
            if ((we_sel == CFGSS_SEL_DONE) && r.done)
            begin
               next_r.we = 1'b1;
            end
         end
         default:
         begin
            next_r.state = CFGSS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         r <= '{state: CFGSS_IDLE, ctrl: CFGSS_CTRL_RST, phase: 4'h0, done_hit: 1'b0,
                done: 1'b0, io_rel: 1'b0, we: 1'b0, rdata: 32'h0};
      end
      else
      begin
         r <= next_r;
      end
   end

   // outputs straight from state, except pslverr_o decoded from the bus inputs; zero wait states on the bus
   // unmapped offsets answer with an error and read back zero
   always_comb
   begin
      prdata_o       = r.rdata;
      pready_o       = 1'b1;
      pslverr_o      = psel_i && penable_i && (paddr_i != CFGSS_CTRL_OFS)
                       && (paddr_i != CFGSS_STATUS_OFS) && (paddr_i != CFGSS_START_OFS);
      done_o         = r.done;
      io_release_o   = r.io_rel;
      write_enable_o = r.we;
      bram_enable_o  = r.we;
      // hold spans loading and the phases before write enable; set/reset spans loading only
      global_interconnect_hold_o = !r.ctrl[CFGSS_AREC_BIT] && !r.we
                                   && (r.state != CFGSS_FIN);
      global_set_reset_o         = !r.ctrl[CFGSS_AREC_BIT] && (r.state == CFGSS_IDLE);
      phase_o        = r.phase[2:0];
   end

endmodule : cfgss_sequencer

`default_nettype wire

// *** include/cfgss_pkg.sv ***
// constants and types for the configuration startup sequencer
// assumes a single 20 MHz configuration clock and registers reached over apb
//
// Operation
// - done rises one clock after entering the selected phase 1..6, or never when the keep choice is set; default 4.
// - with the done pipeline option set, done rises one clock later than the selected phase.
// - io three-state release happens at phase 1..6, one clock after done (with done when pipelined), or never; default 5.
// - global write enable rises at phase 1..6, one clock after done (with done when pipelined), or never; default 6.
// - block ram reads and writes stay off until global write enable and turn on with it.
// - the sequence can wait at a chosen phase 0..6 until all clock generators lock, or not wait.
// - the sequence can wait at a chosen phase for the calibration match, without starting calibration.
// - the automatic match-wait choice resolves to phase 2 when calibrated io is used, else no wait.
// - with active reconfiguration set, interconnect hold and set/reset are never asserted.
package cfgss_pkg;

   localparam int unsigned CFGSS_ADDR_W = 12;

   // register byte offsets
   localparam logic [11:0] CFGSS_CTRL_OFS   = 12'h000;
   localparam logic [11:0] CFGSS_STATUS_OFS = 12'h004;
   localparam logic [11:0] CFGSS_START_OFS  = 12'h008;

   // control field positions
   localparam int unsigned CFGSS_DONE_LSB   = 0;
   localparam int unsigned CFGSS_IO_LSB     = 4;
   localparam int unsigned CFGSS_WE_LSB     = 8;
   localparam int unsigned CFGSS_LOCK_LSB   = 12;
   localparam int unsigned CFGSS_MATCH_LSB  = 16;
   localparam int unsigned CFGSS_PIPE_BIT   = 20;
   localparam int unsigned CFGSS_AREC_BIT   = 21;
   localparam int unsigned CFGSS_CALIO_BIT  = 22;

   // phase select codes: 0..6 a phase, then the symbolic choices
   localparam logic [3:0] CFGSS_SEL_DONE   = 4'h8;
   localparam logic [3:0] CFGSS_SEL_KEEP   = 4'h9;
   localparam logic [3:0] CFGSS_SEL_NO_WAIT_CHOICE = 4'hA;
   localparam logic [3:0] CFGSS_SEL_AUTO   = 4'hB;
   localparam logic [3:0] CFGSS_AUTO_PHASE = 4'h2;
   localparam logic [3:0] CFGSS_LAST_PHASE = 4'h7;

   // control reset value: done 4, io 5, we 6, lock no_wait_choice, match auto
   localparam logic [31:0] CFGSS_CTRL_RST = 32'h000BA654;

   typedef enum logic [1:0]
   {
      CFGSS_IDLE = 2'b00,
      CFGSS_RUN  = 2'b01,
      CFGSS_FIN  = 2'b10
   } cfgss_state_type;

endpackage : cfgss_pkg

// *** testbench/cfgss_sequencer_chk.sv ***
// port checker for the startup sequencer
// assumes bind onto cfgss_sequencer; control written only while idle
`timescale 1ns/1ns
`default_nettype none
module cfgss_chk
   import cfgss_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        rst_b_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        pslverr_o,
   input wire logic        clk_lock_i,
   input wire logic        match_i,
   input wire logic        done_o,
   input wire logic        io_release_o,
   input wire logic        write_enable_o,
   input wire logic        bram_enable_o,
   input wire logic        global_interconnect_hold_o,
   input wire logic        global_set_reset_o,
   input wire logic [2:0]  phase_o
);
   logic [31:0] ctrl;
   logic [3:0]  msel;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // shadow of control; writes outside idle are refused by the block
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
      if (!rst_b_i)
         ctrl <= CFGSS_CTRL_RST;
      else if (psel_i && penable_i && pwrite_i && paddr_i == CFGSS_CTRL_OFS && phase_o == 3'h0
               && !done_o)
         ctrl <= pwdata_i;
   assign msel = ctrl[19:16] != CFGSS_SEL_AUTO ? ctrl[19:16] :
                 ctrl[22] ? CFGSS_AUTO_PHASE : CFGSS_SEL_NO_WAIT_CHOICE;
   a_bram_with_we: assert property (bram_enable_o == write_enable_o)
      else $error("bram enable differs from write enable");
   a_phase_step: assert property ($changed(phase_o) |->
      phase_o == $past(phase_o) + 3'h1 || phase_o == 3'h0) else $error("phase jumped");
   a_done_phase: assert property ($rose(done_o) |->
      {1'b0, (ctrl[20] ? $past(phase_o, 2) : $past(phase_o))} == ctrl[3:0])
      else $error("done at wrong phase");
   a_io_phase: assert property ($rose(io_release_o) |-> (ctrl[7:4] == CFGSS_SEL_DONE ?
      done_o : {1'b0, $past(phase_o)} == ctrl[7:4])) else $error("io release at wrong phase");
   a_we_phase: assert property ($rose(write_enable_o) |-> (ctrl[11:8] == CFGSS_SEL_DONE ?
      done_o : {1'b0, $past(phase_o)} == ctrl[11:8])) else $error("write enable wrong phase");
   a_lock_stall: assert property ({1'b0, phase_o} == ctrl[15:12] && !clk_lock_i
      |=> $stable(phase_o)) else $error("left lock phase unlocked");
   a_match_stall: assert property ({1'b0, phase_o} == msel && !match_i
      |=> $stable(phase_o)) else $error("left match phase unmatched");
   a_no_hold: assert property (ctrl[21] |-> !global_interconnect_hold_o
      && !global_set_reset_o) else $error("hold or set/reset under reconfig");
   a_unmapped_err: assert property (psel_i && penable_i && paddr_i[1:0] == 2'h0
      |-> pslverr_o == (paddr_i > CFGSS_START_OFS)) else $error("wrong slave error");
   c_done: cover property ($rose(done_o));
   c_stall: cover property ({1'b0, phase_o} == ctrl[15:12] && !clk_lock_i);
   c_arec: cover property (ctrl[21] && write_enable_o);
endmodule : cfgss_chk
bind cfgss_sequencer cfgss_chk i_cfgss_chk (.ref_clk_i, .rst_b_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .pslverr_o, .clk_lock_i, .match_i, .done_o, .io_release_o,
   .write_enable_o, .bram_enable_o, .global_interconnect_hold_o, .global_set_reset_o, .phase_o);
`default_nettype wire

// *** testbench/cfgss_sequencer_tb.sv ***
// self-checking bench: apb master, source model, queued read checks
// assumes checker bound through its own file
`timescale 1ns/1ns
`default_nettype none
module cfgss_sequencer_tb;
   import cfgss_pkg::*;
   logic        ref_clk_i = 1'b0;
   logic        rst_b_i   = 1'b0;
   logic        psel      = 1'b0;
   logic        pen       = 1'b0;
   logic        pwr       = 1'b0;
   logic        go        = 1'b0;
   logic [11:0] pa        = 12'h000;
   logic [31:0] pwd       = 32'h0;
   logic [2:0]  stall     = 3'h0;
   logic [31:0] prd;
   logic        prdy, perr, ld, lk, mt;
   logic [2:0]  phase;
   logic [64:0] x;
   logic [64:0] expq[$];
   int          seed = 32'h4611DBD0;
   int          fail_count = 0;
   int          cmp_count = 0;
   always #25 ref_clk_i = ~ref_clk_i;
   cfgss_src_model i_cfgss_src_model (.ref_clk_i, .rst_b_i, .go_i(go), .stall_i(stall),
      .load_done_o(ld), .clk_lock_o(lk), .match_o(mt));
   cfgss_sequencer i_cfgss_sequencer (.ref_clk_i, .rst_b_i, .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
      .pslverr_o(perr), .load_done_i(ld), .clk_lock_i(lk), .match_i(mt), .done_o(),
      .io_release_o(), .write_enable_o(), .bram_enable_o(), .global_interconnect_hold_o(),
      .global_set_reset_o(), .phase_o(phase));
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge ref_clk_i);
      pen <= 1'b1;
      do @(posedge ref_clk_i); while (prdy !== 1'b1 && ++n < 50);
      if (prdy !== 1'b1)
      begin
         $display("BAD %0t no ready", $time);
         fail_count++;
      end
      psel <= 1'b0;
      pen <= 1'b0;
      // idle edge so the next call never reassigns psel in this step
      @(posedge ref_clk_i);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] e, m, input logic er);
      expq.push_back({e, m, er});
      apb(1'b0, a, 32'h0);
   endtask : rd
   function automatic logic [31:0] st(input logic [31:0] c);
      logic d, i, w;
      d = c[3:0] != CFGSS_SEL_KEEP;
      i = c[7:4] == CFGSS_SEL_DONE ? d : c[7:4] != CFGSS_SEL_KEEP;
      w = c[11:8] == CFGSS_SEL_DONE ? d : c[11:8] != CFGSS_SEL_KEEP;
      return {22'h0, w, i, d, 2'b10, 5'h0};
   endfunction : st
   always @(posedge ref_clk_i)
      if (psel && pen && prdy === 1'b1 && !pwr)
      begin
         x = expq.pop_front();
         cmp_count++;
         if ((prd & x[32:1]) !== (x[64:33] & x[32:1]) || perr !== x[0])
         begin
            $display("BAD %0t read %h got %h", $time, pa, prd);
            fail_count++;
         end
      end
   task automatic final_report;
      $display("mismatches %0d compares %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report
   initial
   begin
      #1000000;
      fail_count++;
      final_report();
   end
   initial
   begin
      logic [31:0] cfg [5];
      cfg = '{32'h000BA654, 32'h005B0586, 32'h002A3999, 32'h0004A811, 32'h00066162};
      foreach (cfg[k])
      begin
         rst_b_i <= 1'b0;
         go <= 1'b0;
         repeat (4) @(posedge ref_clk_i);
         rst_b_i <= 1'b1;
         @(posedge ref_clk_i);
         rd(CFGSS_CTRL_OFS, CFGSS_CTRL_RST, 32'hFFFFFFFF, 1'b0);
         apb(1'b1, CFGSS_CTRL_OFS, cfg[k]);
         rd(CFGSS_CTRL_OFS, cfg[k], 32'hFFFFFFFF, 1'b0);
         stall <= 3'($random(seed));
         go <= 1'b1;
         for (int n = 0; n < 200 && phase !== 3'h7; n++) @(posedge ref_clk_i);
         repeat (3) @(posedge ref_clk_i);
         rd(CFGSS_STATUS_OFS, st(cfg[k]), 32'h3E0, 1'b0);
      end
      // control is frozen once the sequence has left idle
      apb(1'b1, CFGSS_CTRL_OFS, $random(seed));
      rd(CFGSS_CTRL_OFS, cfg[4], 32'hFFFFFFFF, 1'b0);
      // restart from finished with loading low: everything back to idle
      go <= 1'b0;
      apb(1'b1, CFGSS_START_OFS, 32'h1);
      rd(CFGSS_STATUS_OFS, 32'h0, 32'h3FF, 1'b0);
      apb(1'b1, 12'h010, $random(seed));
      rd(12'h00C, 32'h0, 32'hFFFFFFFF, 1'b1);
      final_report();
   end
endmodule : cfgss_sequencer_tb
`default_nettype wire

// *** testbench/cfgss_src_model.sv ***
// far-side source: load end, clock lock and calibration match levels
// assumes go_i is held high from start of startup until the next reset
`timescale 1ns/1ns
`default_nettype none
module cfgss_src_model
(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       go_i,
   input  wire logic [2:0] stall_i,
   output logic            load_done_o,
   output logic            clk_lock_o,
   output logic            match_o
);
   logic [3:0] cnt;
   // settling runs on its own time, never triggered by a phase
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
      if (!rst_b_i)
         cnt <= 4'h0;
      else if (load_done_o && cnt != 4'hF)
         cnt <= cnt + 4'h1;
   assign load_done_o = go_i;
   assign clk_lock_o  = load_done_o && cnt >= {1'b0, stall_i};
   assign match_o     = load_done_o && cnt > {1'b0, stall_i};
endmodule : cfgss_src_model
`default_nettype wire
